// file: halfbridge_pwm_pkg.sv
// constants shared by the dithered half-bridge pwm block
package halfbridge_pwm_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PWM_CONTROL         = 8'h51;
  localparam logic [7:0] IDX_DUTY_HIGH           = 8'h52;
  localparam logic [7:0] IDX_DUTY_LOW_AND_STEP   = 8'h53;
  localparam logic [7:0] IDX_PERIOD_HIGH         = 8'h54;
  localparam logic [7:0] IDX_PERIOD_LOW_AND_STEP = 8'h55;
  localparam logic [7:0] IDX_DEADTIME_COUNT      = 8'h56;
  localparam logic [7:0] IDX_TIMEBASE_HIGH       = 8'h57;
  localparam logic [7:0] IDX_TIMEBASE_LOW        = 8'h58;
  localparam logic [7:0] IDX_DITHER_CONTROL      = 8'h59;

  localparam int unsigned APB_ADDR_W = 12;

  // reset values
  localparam logic [7:0] RST_PWM_CONTROL    = 8'h00;
  localparam logic [7:0] RST_DUTY_HIGH      = 8'h00;
  localparam logic [7:0] RST_DUTY_LOW       = 8'h00;
  localparam logic [7:0] RST_PERIOD_HIGH    = 8'h00;
  localparam logic [7:0] RST_PERIOD_LOW     = 8'h00;
  localparam logic [7:0] RST_DEADTIME_COUNT = 8'h08;
  localparam logic [7:0] RST_TIMEBASE_HIGH  = 8'h00;
  localparam logic [7:0] RST_TIMEBASE_LOW   = 8'h00;
  localparam logic [7:0] RST_DITHER_CONTROL = 8'h00;

  // pwm_control bit positions
  localparam int unsigned BIT_SHUTDOWN_PIN_LEVEL    = 6;
  localparam int unsigned BIT_OUTPUT_PIN_ENABLE     = 5;
  localparam int unsigned BIT_SHUTDOWN_FLAG         = 4;
  localparam int unsigned BIT_SHUTDOWN_IRQ_ENABLE   = 3;
  localparam int unsigned BIT_SHUTDOWN_INPUT_ENABLE = 2;
  localparam int unsigned BIT_DITHER_MODE_SELECT    = 1;
  localparam int unsigned BIT_MODULE_ENABLE         = 0;

  // dither_control bit positions and field widths
  localparam int unsigned BIT_DITHER_CLOCK_SOURCE = 3;
  localparam int unsigned STEP_W                  = 5;
  localparam logic [2:0]  SEL_NO_STEPS            = 3'h5;
  localparam int unsigned COUNT_W                 = 16;

  typedef enum logic [0:0] {
    MODE_VARIABLE_FREQUENCY = 1'b0,
    MODE_VARIABLE_DUTY      = 1'b1
  } dither_mode_e;

endpackage

// file: deadtime_gen.sv
// deadtime generator: delays each rising edge, passes falling edges at once
module deadtime_gen (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // waveform
  input  wire logic       raw_in,
  input  wire logic [7:0] deadtime_value,
  output logic            delayed_out
);
  import halfbridge_pwm_pkg::*;

  logic [7:0] wait_count;
  logic       reached;

  assign reached = (wait_count == deadtime_value);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_count  <= 8'h00;
      delayed_out <= 1'b0;
    end else if (!raw_in) begin
      wait_count  <= 8'h00;
      delayed_out <= 1'b0;
    end else if (reached) begin
      delayed_out <= 1'b1;
    end else begin
      wait_count <= wait_count + 8'h01;
    end
  end

endmodule

// file: dithered_halfbridge_pwm.sv
// dithered half-bridge pwm: apb registers, dual frequency generator, dither, pins
module dithered_halfbridge_pwm (
  // clock and reset
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  // apb slave
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [halfbridge_pwm_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                             pwdata,
  output logic [31:0]                                  prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // port logic sharing the drive and shutdown pins
  input  wire logic [1:0]                              port_b_data,
  input  wire logic [1:0]                              port_b_dir,
  input  wire logic                                    port_c_shutdown_dir,
  // high-side drive pin
  output logic                                         high_side_out,
  output logic                                         high_side_oe,
  // low-side drive pin
  output logic                                         low_side_out,
  output logic                                         low_side_oe,
  // shutdown pin
  input  wire logic                                    fault_shutdown_in,
  output logic                                         shutdown_oe,
  output logic                                         shutdown_port_out
);
  import halfbridge_pwm_pkg::*;

  // ---------------- registers ----------------
  logic       module_enable;
  logic       dither_mode_select;
  logic       shutdown_input_enable;
  logic       shutdown_irq_enable;
  logic       shutdown_flag;
  logic       output_pin_enable;
  logic [7:0] duty_high;
  logic [7:0] duty_low_and_step;
  logic [7:0] period_high;
  logic [7:0] period_low_and_step;
  logic [7:0] deadtime_count;
  logic [7:0] timebase_high;
  logic [7:0] timebase_low;
  logic [3:0] dither_control;

  // ---------------- apb decode ----------------
  logic [7:0] reg_index;
  logic       aligned;
  logic       mapped;
  logic       setup_phase;
  logic       write_strobe;
  logic       wr_control;
  logic       wr_duty_high;
  logic       wr_duty_low;
  logic       wr_period_high;
  logic       wr_period_low;
  logic       wr_deadtime;
  logic       wr_timebase_high;
  logic       wr_timebase_low;
  logic       wr_dither;
  logic [7:0] wbyte;
  logic [7:0] control_read;
  logic [7:0] read_byte;

  assign reg_index   = paddr[9:2];
  assign aligned     = (paddr[1:0] == 2'h0) && (paddr[APB_ADDR_W-1:10] == 2'h0);
  assign mapped      = aligned && (reg_index >= IDX_PWM_CONTROL)
                       && (reg_index <= IDX_DITHER_CONTROL);
  assign setup_phase = psel && !penable;
  // pready is a flop that is high only in the first access cycle
  assign write_strobe = psel && penable && pready && pwrite && mapped;
  assign wbyte        = pwdata[7:0];

  assign wr_control       = write_strobe && (reg_index == IDX_PWM_CONTROL);
  assign wr_duty_high     = write_strobe && (reg_index == IDX_DUTY_HIGH);
  assign wr_duty_low      = write_strobe && (reg_index == IDX_DUTY_LOW_AND_STEP);
  assign wr_period_high   = write_strobe && (reg_index == IDX_PERIOD_HIGH);
  assign wr_period_low    = write_strobe && (reg_index == IDX_PERIOD_LOW_AND_STEP);
  assign wr_deadtime      = write_strobe && (reg_index == IDX_DEADTIME_COUNT);
  assign wr_timebase_high = write_strobe && (reg_index == IDX_TIMEBASE_HIGH);
  assign wr_timebase_low  = write_strobe && (reg_index == IDX_TIMEBASE_LOW);
  assign wr_dither        = write_strobe && (reg_index == IDX_DITHER_CONTROL);

  assign control_read = {1'b0, fault_shutdown_in, output_pin_enable, shutdown_flag,
                         shutdown_irq_enable, shutdown_input_enable,
                         dither_mode_select, module_enable};

  assign read_byte =
    (reg_index == IDX_PWM_CONTROL)         ? control_read :
    (reg_index == IDX_DUTY_HIGH)           ? duty_high :
    (reg_index == IDX_DUTY_LOW_AND_STEP)   ? duty_low_and_step :
    (reg_index == IDX_PERIOD_HIGH)         ? period_high :
    (reg_index == IDX_PERIOD_LOW_AND_STEP) ? period_low_and_step :
    (reg_index == IDX_DEADTIME_COUNT)      ? deadtime_count :
    (reg_index == IDX_TIMEBASE_HIGH)       ? timebase_high :
    (reg_index == IDX_TIMEBASE_LOW)        ? timebase_low :
    (reg_index == IDX_DITHER_CONTROL)      ? {4'h0, dither_control} : 8'h00;

  // answer in the first access cycle; read data captured during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
      if (setup_phase) begin
        prdata <= (mapped && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
      end
    end
  end

  // ---------------- shutdown detection ----------------
  logic shutdown_active;
  logic flag_written_low;

  assign shutdown_active  = shutdown_input_enable && !fault_shutdown_in;
  assign flag_written_low = wr_control && !wbyte[BIT_SHUTDOWN_FLAG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable         <= RST_PWM_CONTROL[BIT_MODULE_ENABLE];
      dither_mode_select    <= RST_PWM_CONTROL[BIT_DITHER_MODE_SELECT];
      shutdown_input_enable <= RST_PWM_CONTROL[BIT_SHUTDOWN_INPUT_ENABLE];
      shutdown_irq_enable   <= RST_PWM_CONTROL[BIT_SHUTDOWN_IRQ_ENABLE];
      output_pin_enable     <= RST_PWM_CONTROL[BIT_OUTPUT_PIN_ENABLE];
    end else if (wr_control) begin
      module_enable         <= wbyte[BIT_MODULE_ENABLE];
      dither_mode_select    <= wbyte[BIT_DITHER_MODE_SELECT];
      shutdown_input_enable <= wbyte[BIT_SHUTDOWN_INPUT_ENABLE];
      shutdown_irq_enable   <= wbyte[BIT_SHUTDOWN_IRQ_ENABLE];
      output_pin_enable     <= wbyte[BIT_OUTPUT_PIN_ENABLE];
    end
  end

  // a low pin in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_flag <= RST_PWM_CONTROL[BIT_SHUTDOWN_FLAG];
    end else if (shutdown_active) begin
      shutdown_flag <= 1'b1;
    end else if (flag_written_low) begin
      shutdown_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_high           <= RST_DUTY_HIGH;
      duty_low_and_step   <= RST_DUTY_LOW;
      period_high         <= RST_PERIOD_HIGH;
      period_low_and_step <= RST_PERIOD_LOW;
      deadtime_count      <= RST_DEADTIME_COUNT;
      timebase_high       <= RST_TIMEBASE_HIGH;
      timebase_low        <= RST_TIMEBASE_LOW;
      dither_control      <= RST_DITHER_CONTROL[3:0];
    end else begin
      if (wr_duty_high)     duty_high           <= wbyte;
      if (wr_duty_low)      duty_low_and_step   <= wbyte;
      if (wr_period_high)   period_high         <= wbyte;
      if (wr_period_low)    period_low_and_step <= wbyte;
      if (wr_deadtime)      deadtime_count      <= wbyte;
      if (wr_timebase_high) timebase_high       <= wbyte;
      if (wr_timebase_low)  timebase_low        <= wbyte;
      if (wr_dither)        dither_control      <= wbyte[3:0];
    end
  end

  // ---------------- derived period/duty sets ----------------
  logic [10:0]        period_value;
  logic [10:0]        duty_value;
  logic [15:0]        timebase_value;
  logic [STEP_W-1:0]  step_field;
  logic [2:0]         step_select;
  logic               dither_clock_source;
  logic [COUNT_W-1:0] first_period;
  logic [COUNT_W-1:0] second_period;
  logic [COUNT_W-1:0] first_duty;
  logic [COUNT_W-1:0] second_duty;
  dither_mode_e       mode;

  assign period_value        = {period_high, period_low_and_step[7:5]};
  assign duty_value          = {duty_high, duty_low_and_step[7:5]};
  assign timebase_value      = {timebase_high, timebase_low};
  assign step_select         = dither_control[2:0];
  assign dither_clock_source = dither_control[BIT_DITHER_CLOCK_SOURCE];
  assign mode                = dither_mode_e'(dither_mode_select);

  assign step_field = (mode == MODE_VARIABLE_DUTY) ? duty_low_and_step[STEP_W-1:0]
                                                   : period_low_and_step[STEP_W-1:0];

  // variable frequency: P, P+1, half duty
  assign first_period  = {5'h00, period_value};
  assign second_period = (mode == MODE_VARIABLE_FREQUENCY) ? first_period + 16'h0001
                                                           : first_period;
  assign first_duty    = (mode == MODE_VARIABLE_FREQUENCY) ? {1'b0, first_period[15:1]}
                                                           : {5'h00, duty_value};
  // duty dither: equal period, high time one clock longer
  assign second_duty   = (mode == MODE_VARIABLE_FREQUENCY) ? {1'b0, second_period[15:1]}
                                                           : {5'h00, duty_value} + 16'h0001;

  // ---------------- dithering controller ----------------
  logic [5:0]        step_count;
  logic [STEP_W-1:0] dither_modulus_last;
  logic [STEP_W-1:0] scaled_step;
  logic [STEP_W-1:0] dither_count;
  logic [15:0]       timebase_count;
  logic              timebase_tick;
  logic              dither_tick;
  logic              use_second;
  logic              no_steps;
  logic              period_end;

  // select sets modulus and scaling; reserved codes behave as no steps
  assign no_steps            = (step_select >= SEL_NO_STEPS);
  assign step_count          = no_steps ? 6'h00 : (6'h20 >> step_select);
  assign dither_modulus_last = no_steps ? 5'h00 : 5'(step_count - 6'h01);
  assign scaled_step         = no_steps ? 5'h00 : (step_field >> step_select);
  assign use_second          = (dither_count < scaled_step);

  assign timebase_tick = (timebase_count >= timebase_value);
  // tick from source: timebase terminal count or period end
  assign dither_tick   = dither_clock_source ? timebase_tick : period_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_count <= 16'h0000;
    end else if (!module_enable || timebase_tick) begin
      timebase_count <= 16'h0000;
    end else begin
      timebase_count <= timebase_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_count <= 5'h00;
    end else if (!module_enable) begin
      dither_count <= 5'h00;
    end else if (dither_tick) begin
      dither_count <= (dither_count >= dither_modulus_last) ? 5'h00
                                                            : dither_count + 5'h01;
    end
  end

  // ---------------- dual frequency generator ----------------
  logic [COUNT_W-1:0] wave_count;
  logic [COUNT_W-1:0] active_period;
  logic [COUNT_W-1:0] active_duty;
  logic               wave;

  assign period_end = module_enable && (wave_count + 16'h0001 >= active_period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_count    <= 16'h0000;
      active_period <= 16'h0000;
      active_duty   <= 16'h0000;
    end else if (!module_enable) begin
      wave_count    <= 16'h0000;
      active_period <= first_period;
      active_duty   <= first_duty;
    end else if (period_end) begin
      // values sampled only at period end or while the module is disabled
      wave_count    <= 16'h0000;
      active_period <= use_second ? second_period : first_period;
      active_duty   <= use_second ? second_duty : first_duty;
    end else begin
      wave_count <= wave_count + 16'h0001;
    end
  end

  assign wave = module_enable && (wave_count < active_duty);

  // ---------------- deadtime and pins ----------------
  logic high_side_dt;
  logic low_side_dt;
  logic drive_allowed;
  logic next_high_side_out;
  logic next_low_side_out;

  // waveform and inverse into deadtime paths
  deadtime_gen high_side_deadtime (
    .pclk           (pclk),
    .presetn        (presetn),
    .raw_in         (wave),
    .deadtime_value (deadtime_count),
    .delayed_out    (high_side_dt)
  );

  deadtime_gen low_side_deadtime (
    .pclk           (pclk),
    .presetn        (presetn),
    .raw_in         (module_enable && !wave),
    .deadtime_value (deadtime_count),
    .delayed_out    (low_side_dt)
  );

  // with the pin override on, shutdown holds both drives low until software clears the flag
  assign drive_allowed = module_enable && !shutdown_flag && !shutdown_active;

  // port data drives the pins when not overridden
  assign next_high_side_out = output_pin_enable ? (drive_allowed && high_side_dt)
                                                : port_b_data[0];
  assign next_low_side_out  = output_pin_enable ? (drive_allowed && low_side_dt)
                                                : port_b_data[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_out     <= 1'b0;
      low_side_out      <= 1'b0;
      high_side_oe      <= 1'b0;
      low_side_oe       <= 1'b0;
      shutdown_oe       <= 1'b0;
      shutdown_port_out <= 1'b0;
    end else begin
      high_side_out     <= next_high_side_out;
      low_side_out      <= next_low_side_out;
      high_side_oe      <= output_pin_enable || port_b_dir[0];
      low_side_oe       <= output_pin_enable || port_b_dir[1];
      shutdown_oe       <= !shutdown_input_enable && port_c_shutdown_dir;
      shutdown_port_out <= 1'b0;
    end
  end

endmodule

// file: halfbridge_pwm_checker.sv
// port checks for the dithered half-bridge pwm
module halfbridge_pwm_checker
  import halfbridge_pwm_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [1:0]  port_b_data,
  input wire logic [1:0]  port_b_dir,
  input wire logic        port_c_shutdown_dir,
  input wire logic        high_side_out,
  input wire logic        high_side_oe,
  input wire logic        low_side_out,
  input wire logic        low_side_oe,
  input wire logic        fault_shutdown_in,
  input wire logic        shutdown_oe,
  input wire logic        shutdown_port_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr = psel && penable && pready && pwrite && (paddr == {2'b00, IDX_PWM_CONTROL, 2'b00});

  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_ready_answer; psel && !penable |=> pready; endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("access cycle not answered");
  property p_err_pulse; pslverr |-> pready; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("pslverr without pready");
  property p_err_align; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr; endproperty
  a_err_align: assert property (p_err_align) else $error("misaligned access accepted");
  property p_oe_force; ctl_wr && pwdata[BIT_OUTPUT_PIN_ENABLE] |-> ##2 high_side_oe && low_side_oe;
  endproperty
  a_oe_force: assert property (p_oe_force) else $error("drive pins not forced out");
  property p_shut_in; ctl_wr && pwdata[BIT_SHUTDOWN_INPUT_ENABLE] |-> ##2 !shutdown_oe; endproperty
  a_shut_in: assert property (p_shut_in) else $error("shutdown pin not forced in");
  property p_no_overlap; !(high_side_out && low_side_out); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both sides driven high");
  property p_rise_gap; $rose(high_side_out) |-> $past(!low_side_out); endproperty
  a_rise_gap: assert property (p_rise_gap) else $error("high side rose without gap");
  // only in pwm mode; with the override off the pins follow port data
  property p_disable; ctl_wr && !pwdata[BIT_MODULE_ENABLE] && pwdata[BIT_OUTPUT_PIN_ENABLE]
    |-> ##2 !high_side_out && !low_side_out;
  endproperty
  a_disable: assert property (p_disable) else $error("outputs active while disabled");

  c_err: cover property (pslverr);
  c_rise: cover property ($rose(high_side_out));
  c_mode: cover property (ctl_wr && pwdata[BIT_DITHER_MODE_SELECT]);
endmodule

// file: halfbridge_stage.sv
// power stage and fault sensor model: measures the drive waveform
module halfbridge_stage (
  input  wire logic pclk,
  input  wire logic high_side_out,
  input  wire logic low_side_out,
  input  wire logic fault_req,
  output logic      fault_shutdown_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned rises = 0;
  int unsigned cyc_sum = 0;
  int unsigned hi_sum = 0;
  int unsigned gap = 0;
  int unsigned gap_run = 0;
  logic        hi_d = 1'b0;
  logic        lo_d = 1'b0;
  // sense line has a pull-up, so it reads high unless a fault pulls it
  assign fault_shutdown_in = fault_req ? 1'b0 : 1'b1;
  always @(posedge pclk) begin
    hi_d <= high_side_out;
    lo_d <= low_side_out;
    cyc_sum <= cyc_sum + 1;
    if (high_side_out) hi_sum <= hi_sum + 1;
    if (high_side_out && !hi_d) begin
      rises <= rises + 1;
      gap <= gap_run;
    end
    gap_run <= (lo_d && !low_side_out) ? 1 : gap_run + 1;
  end
endmodule

// file: tb_dithered_halfbridge_pwm.sv
// testbench for the dithered half-bridge pwm
module tb_dithered_halfbridge_pwm;
  timeunit 1ns;
  timeprecision 100ps;
  import halfbridge_pwm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [1:0]  port_b_data = 2'h1, port_b_dir = 2'h0;
  logic        port_c_shutdown_dir = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, high_side_out, high_side_oe, low_side_out, low_side_oe;
  logic        fault_shutdown_in, shutdown_oe, shutdown_port_out;
  int unsigned bad_count = 0, checks_done = 0, cycles = 0;

  always #12.5 pclk = ~pclk;

  dithered_halfbridge_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_b_data(port_b_data), .port_b_dir(port_b_dir),
    .port_c_shutdown_dir(port_c_shutdown_dir), .high_side_out(high_side_out),
    .high_side_oe(high_side_oe), .low_side_out(low_side_out), .low_side_oe(low_side_oe),
    .fault_shutdown_in(fault_shutdown_in), .shutdown_oe(shutdown_oe),
    .shutdown_port_out(shutdown_port_out));
  halfbridge_stage stage (.pclk(pclk), .high_side_out(high_side_out),
    .low_side_out(low_side_out), .fault_req(fault_req), .fault_shutdown_in(fault_shutdown_in));

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // 32 whole high-side periods, after two periods to settle
  task automatic measure(output int unsigned cyc, output int unsigned hi);
    int unsigned r0, c0, h0;
    r0 = stage.rises;
    while (stage.rises < r0 + 2) @(posedge pclk);
    r0 = stage.rises;
    c0 = stage.cyc_sum;
    h0 = stage.hi_sum;
    while (stage.rises < r0 + 32) @(posedge pclk);
    cyc = stage.cyc_sum - c0;
    hi = stage.hi_sum - h0;
  endtask
  task automatic t_regs;
    for (int i = 8'h52; i <= 8'h59; i++) begin
      apb(1'b0, ba(8'(i)), 8'h00);
      chk("reset value", (i == IDX_DEADTIME_COUNT) ? 32'(RST_DEADTIME_COUNT) : 32'h0, rd);
    end
    apb(1'b1, ba(IDX_DITHER_CONTROL), 8'hff);
    apb(1'b0, ba(IDX_DITHER_CONTROL), 8'h00);
    chk("dither_control", 32'h0f, rd);
    apb(1'b0, 12'h200, 8'h00);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h149, 8'h5a);
    chk("misaligned err", 32'h1, 32'(er));
    apb(1'b0, ba(IDX_DUTY_HIGH), 8'h00);
    chk("misaligned write dropped", 32'h0, rd);
  endtask
  task automatic t_pins;
    apb(1'b1, ba(IDX_PWM_CONTROL), 8'h24);
    repeat (3) @(posedge pclk);
    chk("drive oe", 32'h3, {30'h0, high_side_oe, low_side_oe});
    chk("shutdown oe", 32'h0, 32'(shutdown_oe));
    chk("idle outputs", 32'h0, {30'h0, high_side_out, low_side_out});
    apb(1'b1, ba(IDX_PWM_CONTROL), 8'h00);
    repeat (3) @(posedge pclk);
    chk("drive oe by port", 32'h0, {30'h0, high_side_oe, low_side_oe});
    chk("shutdown oe by port", 32'h1, 32'(shutdown_oe));
    chk("port data", 32'h2, {30'h0, high_side_out, low_side_out});
    chk("shutdown drive", 32'h0, 32'(shutdown_port_out));
  endtask
  task automatic t_freq;
    int unsigned c, h;
    logic [4:0]  st [7] = '{5'd0, 5'd8, 5'd8, 5'd31, 5'd31, 5'd31, 5'd16};
    logic [3:0]  sl [7] = '{4'd0, 4'd0, 4'd1, 4'd3, 4'd5, 4'd6, 4'hc};
    int unsigned ex [7] = '{640, 648, 648, 664, 640, 640, 672};
    apb(1'b1, ba(IDX_DEADTIME_COUNT), 8'h01);
    apb(1'b1, ba(IDX_PERIOD_HIGH), 8'h02);
    apb(1'b1, ba(IDX_DUTY_LOW_AND_STEP), 8'h1f);
    // slow timebase keeps the dither count still through the last row
    apb(1'b1, ba(IDX_TIMEBASE_HIGH), 8'hff);
    apb(1'b1, ba(IDX_TIMEBASE_LOW), 8'hff);
    foreach (st[i]) begin
      apb(1'b1, ba(IDX_PERIOD_LOW_AND_STEP), {3'h4, st[i]});
      apb(1'b1, ba(IDX_DITHER_CONTROL), {4'h0, sl[i]});
      // a disabled cycle restarts the dither and timebase counts
      apb(1'b1, ba(IDX_PWM_CONTROL), 8'h20);
      apb(1'b1, ba(IDX_PWM_CONTROL), 8'h21);
      measure(c, h);
      chk("period sum", ex[i], c);
      chk("high sum", 32'd288, h);
    end
    chk("deadtime gap", 32'd1, stage.gap);
  endtask
  task automatic t_duty;
    int unsigned c, h;
    apb(1'b1, ba(IDX_DEADTIME_COUNT), 8'h02);
    apb(1'b1, ba(IDX_PERIOD_LOW_AND_STEP), 8'h9f);
    apb(1'b1, ba(IDX_DUTY_HIGH), 8'h00);
    apb(1'b1, ba(IDX_DUTY_LOW_AND_STEP), 8'hd0);
    apb(1'b1, ba(IDX_DITHER_CONTROL), 8'h00);
    apb(1'b1, ba(IDX_PWM_CONTROL), 8'h23);
    measure(c, h);
    chk("duty period sum", 32'd640, c);
    chk("duty high sum", 32'd144, h);
    chk("deadtime gap", 32'd2, stage.gap);
  endtask
  // fault pulls the sense line low; the flag keeps drives off until cleared
  task automatic t_shut;
    int unsigned r;
    apb(1'b1, ba(IDX_PWM_CONTROL), 8'h27);
    fault_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("outputs in fault", 32'h0, {30'h0, high_side_out, low_side_out});
    apb(1'b0, ba(IDX_PWM_CONTROL), 8'h00);
    chk("control in fault", 32'h37, rd);
    fault_req <= 1'b0;
    r = stage.rises;
    repeat (45) @(posedge pclk);
    chk("held by flag", r, stage.rises);
    apb(1'b1, ba(IDX_PWM_CONTROL), 8'h27);
    apb(1'b0, ba(IDX_PWM_CONTROL), 8'h00);
    chk("control cleared", 32'h67, rd);
    r = stage.rises;
    repeat (45) @(posedge pclk);
    chk("resumed", 32'h1, 32'(stage.rises > r));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // cut a hang short well past the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pins();
    t_freq();
    t_duty();
    t_shut();
    conclude();
  end
endmodule

bind dithered_halfbridge_pwm halfbridge_pwm_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_b_data(port_b_data),
  .port_b_dir(port_b_dir), .port_c_shutdown_dir(port_c_shutdown_dir),
  .high_side_out(high_side_out), .high_side_oe(high_side_oe), .low_side_out(low_side_out),
  .low_side_oe(low_side_oe), .fault_shutdown_in(fault_shutdown_in),
  .shutdown_oe(shutdown_oe), .shutdown_port_out(shutdown_port_out));
